// ### shared/wrcr_pkg.sv
/*
  Constants, register map and state types of the wake rate configuration
  block. Assumes a single device clock and one APB slave port.
*/
`default_nettype none
package wrcr_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_MODE = 6'h10;
  localparam logic [5:0] IDX_RATE = 6'h11;
  localparam logic [5:0] IDX_PWR = 6'h1c;
  localparam logic [5:0] IDX_TUNE = 6'h29;
  localparam logic [5:0] IDX_STAT = 6'h30;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int RATE_CODE_LSB = 0;
  localparam int RATE_SEL_LSB = 4;
  localparam int RATE_RESERVED_BIT_BIT = 7;
  localparam int PWR_MODE_LSB = 4;
  localparam int MODE_SEL_LSB = 0;
  localparam int MODE_AXIS_LSB = 4;
  localparam logic [7:0] RATE_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] PWR_ULP = 3'h3;
  localparam logic [2:0] PWR_LP = 3'h0;
  localparam logic [2:0] PWR_PREC = 3'h4;
  localparam logic [2:0] MODE_SNIFF = 3'h2;
  localparam logic [2:0] MODE_CONTINUOUS_WAKE_MODE = 3'h5;
  localparam logic [2:0] MODE_SWAKE = 3'h6;
  localparam logic [3:0] CODE_SOFT = 4'hf;

  typedef enum logic [2:0] {
    WRCR_SEL_OFF = 3'h0,
    WRCR_SEL_TRIM = 3'h1,
    WRCR_SEL_WFPICK = 3'h2,
    WRCR_SEL_SFPICK = 3'h3,
    WRCR_SEL_WCNT_LO = 3'h4,
    WRCR_SEL_WCNT_HI = 3'h5,
    WRCR_SEL_SCNT_LO = 3'h6,
    WRCR_SEL_SCNT_HI = 3'h7
  } wrcr_sel_t;

  // ----------------------------------------------------------------
  // State of the register bank and of the sample timer
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] rateCfg;
    logic [2:0] powerMode;
    logic [2:0] modeSel;
    logic [2:0] axisOff;
    logic [7:0] biasTrim;
    logic [4:0] wakeFpick;
    logic [4:0] sniffFpick;
    logic [15:0] wakeCount;
    logic [15:0] sniffCount;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rateValid;
    logic [31:0] period;
    logic sampleStrobe;
    logic [2:0] axisEnable;
    logic sniffActive;
  } wrcr_state_t;

  typedef struct packed {
    logic [31:0] count;
    logic tick;
  } wrcr_timer_t;

  // Wake rate in Hz per code; index 0 ultra-low, 1 low, 2 precision.
  // Zero marks a code that the power mode cannot serve.
  function automatic int unsigned wrcr_odr_hz(input logic [3:0] code,
                                              input logic [1:0] pmIdx);
    logic [2:0][10:0] t;
    t = '0;
    case (code)
      4'h5: t = {11'h000, 11'h00e, 11'h00e};
      4'h6: t = {11'h019, 11'h01c, 11'h01c};
      4'h7: t = {11'h032, 11'h036, 11'h037};
      4'h8: t = {11'h064, 11'h069, 11'h050};
      4'h9: t = {11'h0be, 11'h0d2, 11'h000};
      4'ha: t = {11'h17c, 11'h190, 11'h000};
      4'hb: t = {11'h2ee, 11'h258, 11'h000};
      4'hc: t = {11'h44c, 11'h000, 11'h000};
      4'hf: t = {11'h514, 11'h2ee, 11'h064};
      default: t = '0;
    endcase
    case (pmIdx)
      2'h0: return int'(t[2]);
      2'h1: return int'(t[1]);
      2'h2: return int'(t[0]);
      default: return 0;
    endcase
  endfunction

endpackage
`default_nettype wire

// ### shared/wrcr_rate_if.sv
/*
  Link between the register bank and the sample timer.
  Assumes both ends sit on the same clock.
*/
`default_nettype none
interface wrcr_rate_if;
  logic enable;
  logic [31:0] period;
  logic tick;
  modport ctrl (output enable, output period, input tick);
  modport gen (input enable, input period, output tick);
endinterface
`default_nettype wire

// ### hw/wrcr_timer.sv
/*
  Sample timer: one tick every period cycles while enabled.
  Assumes period is at least one whenever enable is high.
*/
`default_nettype none
module wrcr_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Rate link
  wrcr_rate_if.gen rate
);

  wrcr_pkg::wrcr_timer_t st_q, st_d;

  always_comb begin
    st_d = st_q;
    st_d.tick = 1'b0;
    if (!rate.enable) begin
      st_d.count = 32'h0;
    end else if (st_q.count >= rate.period - 32'h1) begin
      // Compare, not equal: a period shortened mid-count still wraps
      st_d.count = 32'h0;
      st_d.tick = 1'b1;
    end else begin
      st_d.count = st_q.count + 32'h1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rate.tick = st_q.tick;

endmodule
`default_nettype wire

// ### hw/wrcr_top.sv
/*
  Wake rate configuration register bank behind an APB slave, with the
  manual tuning shadow registers and the wake sample timer.
  Assumes an APB master on the same clock; one wait-free access cycle.
*/
// Operation
// RULE_01 - Low four bits of the rate register pick the wake sample rate.
// RULE_02 - Effective wake rate depends on rate code and power mode together.
// RULE_03 - Only codes 5..C and F are valid, limited per power mode.
// RULE_04 - Software runs a setup sequence before choosing the software rate.
// RULE_05 - Select zero disables manual tuning and exposes no shadow register.
// RULE_06 - Three-bit select picks which shadow register the tuning port reaches.
// RULE_07 - Selects 1..3 expose bias trims and the two frequency picks.
// RULE_08 - Selects 4..7 expose low and high bytes of both clock counts.
// RULE_09 - Continuous wake samples enabled axes at wake rate, sniff inactive.
// RULE_10 - Reserved top rate bit is ignored on write and reads zero.
`default_nettype none
module wrcr_top #(
  parameter int unsigned CLK_HZ = 40_000_000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sampling
  output logic sampleStrobe,
  output logic [2:0] axisEnable,
  output logic sniffActive
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  // The fastest rate must still give a period of two cycles or more
  if (CLK_HZ < 2600) begin : g_clk_check
    $error("CLK_HZ too low for the fastest wake rate");
  end

  // ----------------------------------------------------------------
  // Period table per power mode and code
  // ----------------------------------------------------------------
  logic [31:0] periodTab [3][16];

  for (genvar k = 0; k < 3; k++) begin : g_pm
    for (genvar c = 0; c < 16; c++) begin : g_code
      localparam int unsigned HZ = wrcr_pkg::wrcr_odr_hz(4'(c), 2'(k));
      localparam int unsigned DIV = (HZ == 0) ? 1 : HZ;
      assign periodTab[k][c] = (HZ == 0) ? 32'h0 : 32'(CLK_HZ / DIV);
    end
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  wrcr_pkg::wrcr_state_t st_q, st_d;
  wrcr_rate_if rateLink ();

  logic [3:0] rateCode;
  logic [2:0] tuneSel;
  logic [1:0] pmIdx;
  logic pmKnown;
  logic [31:0] tablePeriod;
  logic [31:0] periodNow;
  logic wakeMode;
  logic setup;
  logic wrEn;
  logic mapped;
  logic [7:0] tuneRead;
  logic [31:0] readData;

  assign rateCode = st_q.rateCfg[wrcr_pkg::RATE_CODE_LSB +: 4]; // RULE_01
  assign tuneSel = st_q.rateCfg[wrcr_pkg::RATE_SEL_LSB +: 3];
  assign setup = psel && !penable;
  // Misaligned or unmapped writes are answered but change nothing
  assign wrEn = psel && penable && st_q.pready && pwrite && pstrb[0] &&
                mapped;
  assign wakeMode = (st_q.modeSel == wrcr_pkg::MODE_CONTINUOUS_WAKE_MODE) ||
                    (st_q.modeSel == wrcr_pkg::MODE_SWAKE);

  // ----------------------------------------------------------------
  // Rate decode
  // ----------------------------------------------------------------
  always_comb begin
    pmKnown = 1'b1;
    case (st_q.powerMode) // RULE_02
      wrcr_pkg::PWR_ULP: pmIdx = 2'h0;
      wrcr_pkg::PWR_LP: pmIdx = 2'h1;
      wrcr_pkg::PWR_PREC: pmIdx = 2'h2;
      default: begin
        pmIdx = 2'h0;
        pmKnown = 1'b0;
      end
    endcase
    tablePeriod = pmKnown ? periodTab[pmIdx][rateCode] : 32'h0; // RULE_03
    // Software rate runs off the programmed wake clock count
    if (rateCode == wrcr_pkg::CODE_SOFT && pmKnown) begin
      periodNow = {16'h0, st_q.wakeCount};
    end else begin
      periodNow = tablePeriod;
    end
  end

  // ----------------------------------------------------------------
  // Tuning port read and APB decode
  // ----------------------------------------------------------------
  always_comb begin
    case (wrcr_pkg::wrcr_sel_t'(tuneSel)) // RULE_06
      wrcr_pkg::WRCR_SEL_OFF: tuneRead = 8'h00; // RULE_05
      wrcr_pkg::WRCR_SEL_TRIM: tuneRead = st_q.biasTrim; // RULE_07
      wrcr_pkg::WRCR_SEL_WFPICK: tuneRead = {3'h0, st_q.wakeFpick};
      wrcr_pkg::WRCR_SEL_SFPICK: tuneRead = {3'h0, st_q.sniffFpick};
      wrcr_pkg::WRCR_SEL_WCNT_LO: tuneRead = st_q.wakeCount[7:0]; // RULE_08
      wrcr_pkg::WRCR_SEL_WCNT_HI: tuneRead = st_q.wakeCount[15:8];
      wrcr_pkg::WRCR_SEL_SCNT_LO: tuneRead = st_q.sniffCount[7:0];
      wrcr_pkg::WRCR_SEL_SCNT_HI: tuneRead = st_q.sniffCount[15:8];
      default: tuneRead = 8'h00;
    endcase
    mapped = (paddr[1:0] == 2'h0);
    readData = 32'h0;
    case (paddr[7:2])
      wrcr_pkg::IDX_MODE:
        readData = {24'h0, 1'b0, st_q.axisOff, 1'b0, st_q.modeSel};
      wrcr_pkg::IDX_RATE: readData = {24'h0, st_q.rateCfg};
      wrcr_pkg::IDX_PWR:
        readData = {24'h0, 1'b0, st_q.powerMode, 4'h0};
      wrcr_pkg::IDX_TUNE: readData = {24'h0, tuneRead};
      wrcr_pkg::IDX_STAT:
        readData = {29'h0, st_q.sniffActive, st_q.sampleStrobe,
                    st_q.rateValid};
      default: mapped = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    // Answer one cycle after setup: prdata and pready stay registered
    st_d.pready = setup;
    st_d.pslverr = setup && !mapped;
    if (setup && !pwrite) begin
      st_d.prdata = mapped ? readData : 32'h0;
    end
    if (wrEn) begin
      case (paddr[7:2])
        wrcr_pkg::IDX_MODE: begin
          st_d.modeSel = pwdata[wrcr_pkg::MODE_SEL_LSB +: 3];
          st_d.axisOff = pwdata[wrcr_pkg::MODE_AXIS_LSB +: 3];
        end
        wrcr_pkg::IDX_RATE: begin
          st_d.rateCfg = {1'b0, pwdata[6:0]}; // RULE_10
        end
        wrcr_pkg::IDX_PWR: begin
          st_d.powerMode = pwdata[wrcr_pkg::PWR_MODE_LSB +: 3];
        end
        wrcr_pkg::IDX_TUNE: begin
          case (wrcr_pkg::wrcr_sel_t'(tuneSel)) // RULE_06
            wrcr_pkg::WRCR_SEL_TRIM: st_d.biasTrim = pwdata[7:0]; // RULE_07
            wrcr_pkg::WRCR_SEL_WFPICK: st_d.wakeFpick = pwdata[4:0];
            wrcr_pkg::WRCR_SEL_SFPICK: st_d.sniffFpick = pwdata[4:0];
            wrcr_pkg::WRCR_SEL_WCNT_LO: st_d.wakeCount[7:0] = pwdata[7:0];
            wrcr_pkg::WRCR_SEL_WCNT_HI: st_d.wakeCount[15:8] = pwdata[7:0];
            wrcr_pkg::WRCR_SEL_SCNT_LO: st_d.sniffCount[7:0] = pwdata[7:0];
            wrcr_pkg::WRCR_SEL_SCNT_HI: st_d.sniffCount[15:8] = pwdata[7:0];
            default: st_d.biasTrim = st_q.biasTrim; // RULE_05
          endcase
        end
        default: st_d.rateCfg = st_q.rateCfg;
      endcase
    end
    // A zero period means the code is not served in this power mode
    st_d.rateValid = (periodNow != 32'h0); // RULE_03
    st_d.period = periodNow; // RULE_02
    st_d.axisEnable = wakeMode ? ~st_q.axisOff : 3'h0; // RULE_09
    st_d.sniffActive = (st_q.modeSel == wrcr_pkg::MODE_SNIFF) ||
                       (st_q.modeSel == wrcr_pkg::MODE_SWAKE); // RULE_09
    st_d.sampleStrobe = rateLink.tick;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q <= '0;
      st_q.rateCfg <= wrcr_pkg::RATE_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Sample timer
  // ----------------------------------------------------------------
  assign rateLink.enable = st_q.rateValid && (st_q.axisEnable != 3'h0);
  assign rateLink.period = st_q.period;

  wrcr_timer u_timer (
    .clk(clk),
    .reset(reset),
    .rate(rateLink)
  );

  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign sampleStrobe = st_q.sampleStrobe;
  assign axisEnable = st_q.axisEnable;
  assign sniffActive = st_q.sniffActive;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  logic tuneRd;
  assign tuneRd = setup && !pwrite && paddr == {wrcr_pkg::IDX_TUNE, 2'h0};

  chk_code_drives_rate: assert property ( // RULE_01
    rateCode == 4'h0 |=> !st_q.rateValid)
    else $error("Code zero gave a valid rate");
  chk_power_sets_rate: assert property ( // RULE_02
    (rateCode == 4'h7 && st_q.powerMode == wrcr_pkg::PWR_ULP)
      ##1 (rateCode == 4'h7 && st_q.powerMode == wrcr_pkg::PWR_ULP)
      |-> st_q.period == 32'(CLK_HZ / 50))
    else $error("Ultra-low code 7 period wrong");
  chk_prec_refuse: assert property ( // RULE_03
    (st_q.powerMode == wrcr_pkg::PWR_PREC && rateCode >= 4'h9 &&
     rateCode <= 4'hb) |=> !st_q.rateValid ##2 !st_q.sampleStrobe)
    else $error("Precision mode accepted code 9 to b");
  chk_sel_off_hold: assert property ( // RULE_05
    (wrEn && paddr[7:2] == wrcr_pkg::IDX_TUNE && tuneSel == 3'h0)
      |=> $stable(st_q.biasTrim) && $stable(st_q.wakeCount) &&
          $stable(st_q.sniffCount) && $stable(st_q.wakeFpick))
    else $error("Tuning write with select zero changed a shadow");
  chk_sel_read_pick: assert property ( // RULE_06
    (tuneRd && tuneSel == 3'h2) |=> prdata == {27'h0, $past(st_q.wakeFpick)})
    else $error("Select 2 read wrong shadow");
  chk_trim_pack: assert property ( // RULE_07
    (tuneRd && tuneSel == 3'h1) |=> prdata[7:0] == $past(st_q.biasTrim)
      && pready)
    else $error("Bias trim read wrong");
  chk_count_bytes: assert property ( // RULE_08
    (tuneRd && tuneSel == 3'h7)
      |=> prdata[7:0] == $past(st_q.sniffCount[15:8]))
    else $error("Sniff count high byte read wrong");
  chk_continuous_wake_mode_no_sniff: assert property ( // RULE_09
    st_q.modeSel == wrcr_pkg::MODE_CONTINUOUS_WAKE_MODE |=> !sniffActive &&
      axisEnable == ~$past(st_q.axisOff))
    else $error("Continuous wake left sniff on or axes wrong");
  chk_reserved_bit_zero: assert property ( // RULE_10
    st_q.rateCfg[wrcr_pkg::RATE_RESERVED_BIT_BIT] == 1'b0)
    else $error("Reserved rate bit set");

  // Register reads, refused accesses and codes, software rate period and idle sampling
  chk_sel_off_read: assert property ( // RULE_05
    (tuneRd && tuneSel == 3'h0)
      |=> prdata == 32'h0)
    else $error("Select zero read a shadow register");
  chk_sniff_pick: assert property ( // RULE_07
    (tuneRd && tuneSel == 3'h3)
      |=> prdata == {27'h0, $past(st_q.sniffFpick)})
    else $error("Select 3 read wrong shadow");
  chk_wake_count: assert property ( // RULE_08
    (tuneRd && tuneSel == 3'h5)
      |=> prdata == {24'h0, $past(st_q.wakeCount[15:8])})
    else $error("Wake count high byte read wrong");
  chk_reserved_bit_read: assert property ( // RULE_10
    (setup && !pwrite && paddr == {wrcr_pkg::IDX_RATE, 2'h0})
      |=> pready && prdata[7] == 1'b0)
    else $error("Reserved rate bit read back set");
  chk_refused_write: assert property ( // RULE_01
    (psel && penable && pready && pwrite && paddr[1:0] != 2'h0)
      |=> $stable(st_q.rateCfg) && $stable(st_q.modeSel) &&
          $stable(st_q.powerMode))
    else $error("Misaligned write changed a register");
  chk_slverr_pair: assert property ( // RULE_01
    (setup && paddr[1:0] != 2'h0) |=> pslverr && pready)
    else $error("Misaligned access not refused");
  chk_strobe_off: assert property ( // RULE_09
    (axisEnable == 3'h0) ##1 (axisEnable == 3'h0) |=> !sampleStrobe)
    else $error("Strobe with no axis enabled");
  chk_soft_period: assert property ( // RULE_02
    (rateCode == wrcr_pkg::CODE_SOFT && st_q.powerMode == wrcr_pkg::PWR_LP)
      |=> st_q.period == {16'h0, $past(st_q.wakeCount)})
    else $error("Software rate period differs from wake count");
  chk_ulp_only_c: assert property ( // RULE_03
    (rateCode == 4'hc && st_q.powerMode != wrcr_pkg::PWR_ULP)
      |=> !st_q.rateValid)
    else $error("Code c accepted outside ultra-low power");

  cov_continuous_wake_mode_sample: cover property (
    st_q.modeSel == wrcr_pkg::MODE_CONTINUOUS_WAKE_MODE && sampleStrobe);
  cov_tune_write: cover property (
    wrEn && paddr[7:2] == wrcr_pkg::IDX_TUNE && tuneSel != 3'h0);
  cov_soft_rate: cover property (rateCode == wrcr_pkg::CODE_SOFT &&
    st_q.rateValid);
  cov_bad_addr: cover property (pslverr);
  cov_prec_refused: cover property (
    st_q.powerMode == wrcr_pkg::PWR_PREC && rateCode == 4'h9);

endmodule
`default_nettype wire

// ### testbench/wrcr_testbench.sv
/*
  Self-checking bench of the wake rate configuration block over APB.
  Assumes a shortened clock rate parameter, so that sample periods stay
  a few hundred cycles; the bus master waits for pready, bounded.
*/
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Signals and design
  // ----------------------------------------------------------------
  localparam int unsigned HZ = 40000;
  localparam logic [7:0] A_MODE = {wrcr_pkg::IDX_MODE, 2'b00};
  localparam logic [7:0] A_RATE = {wrcr_pkg::IDX_RATE, 2'b00};
  localparam logic [7:0] A_PWR = {wrcr_pkg::IDX_PWR, 2'b00};
  localparam logic [7:0] A_TUNE = {wrcr_pkg::IDX_TUNE, 2'b00};
  localparam logic [7:0] A_STAT = {wrcr_pkg::IDX_STAT, 2'b00};
  logic clk, reset, psel, penable, pwrite, pready, pslverr;
  logic sampleStrobe, sniffActive;
  logic [2:0] axisEnable;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [3:0] pstrb;
  logic re;
  int miscompares, comparisons, n, k;
  // Shadow data written and read back per select value
  logic [7:0] wv [8] = '{8'h00, 8'ha5, 8'hff, 8'hea, 8'h34, 8'h12, 8'h78,
    8'h56};
  logic [7:0] ev [8] = '{8'h00, 8'ha5, 8'h1f, 8'h0a, 8'h34, 8'h12, 8'h78,
    8'h56};
  // Power setting, rate code and period in cycles (0 means no sampling)
  logic [7:0] pw [8] = '{8'h30, 8'h30, 8'h40, 8'h00, 8'h30, 8'h00, 8'h40,
    8'h10};
  logic [3:0] cd [8] = '{4'h7, 4'h8, 4'h8, 4'ha, 4'h5, 4'hc, 4'h9, 4'h7};
  int ex [8] = '{800, 400, 500, 100, 0, 0, 0, 0};

  wrcr_top #(.CLK_HZ(HZ)) dut_u (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sampleStrobe(sampleStrobe), .axisEnable(axisEnable),
    .sniffActive(sniffActive));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Report and compare tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic fail(input string m);
    miscompares++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) fail($sformatf("word %h, expected %h", got, exp));
  endtask

  task automatic check_flag(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) fail($sformatf("flag %b, expected %b", got, exp));
  endtask

  task automatic check_count(input int got, input int exp);
    comparisons++;
    if (got != exp) fail($sformatf("count %0d, expected %0d", got, exp));
  endtask

  // ----------------------------------------------------------------
  // Bus and timing tasks
  // ----------------------------------------------------------------
  // Request held until the rising edge that sees pready, released there
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    if (pready !== 1'b1) begin
      fail("no pready");
      give_verdict();
    end
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                        input logic err);
    apb(1'b0, a, 32'h0);
    check_word(rv, exp);
    check_flag(re, err);
  endtask

  // Gap between two strobes; a missing strobe ends the run
  task automatic measure(output int gap);
    int i;
    for (i = 0; i < 4000 && sampleStrobe !== 1'b1; i++) @(negedge clk);
    @(negedge clk);
    for (gap = 1; gap < 4000 && sampleStrobe !== 1'b1; gap++) begin
      @(negedge clk);
    end
    if (gap >= 4000) begin
      fail("no sample strobe");
      give_verdict();
    end
  endtask

  task automatic quiet(output int hits);
    hits = 0;
    repeat (4) @(negedge clk);
    repeat (1000) begin
      @(negedge clk);
      if (sampleStrobe === 1'b1) hits++;
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    reset = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'h1;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    check_word({29'h0, sampleStrobe, sniffActive, axisEnable != 3'h0}, 0);
    rd_chk(A_RATE, 32'h0, 1'b0);
    rd_chk(A_TUNE, 32'h0, 1'b0);
    $display("test reset done");

    wr(A_RATE, 8'hff);
    rd_chk(A_RATE, 32'h7f, 1'b0);
    wr(A_RATE, 8'h80);
    rd_chk(A_RATE, 32'h00, 1'b0);
    for (k = 1; k < 8; k++) begin
      wr(A_RATE, {1'b0, 3'(k), 4'h0});
      wr(A_TUNE, wv[k]);
    end
    for (k = 7; k > 0; k--) begin
      wr(A_RATE, {1'b0, 3'(k), 4'h0});
      rd_chk(A_TUNE, {24'h0, ev[k]}, 1'b0);
    end
    wr(A_RATE, 8'h00);
    wr(A_TUNE, 8'h99);
    rd_chk(A_TUNE, 32'h0, 1'b0);
    wr(A_RATE, 8'h10);
    rd_chk(A_TUNE, 32'ha5, 1'b0);
    $display("test shadow done");

    rd_chk(8'h80, 32'h0, 1'b1);
    apb(1'b1, A_RATE | 8'h01, 32'h0a);
    check_flag(re, 1'b1);
    pstrb <= 4'h0;
    wr(A_RATE, 8'h0b);
    pstrb <= 4'h1;
    rd_chk(A_RATE, 32'h10, 1'b0);
    $display("test bus errors done");

    wr(A_MODE, 8'h05);
    repeat (3) @(negedge clk);
    check_word({28'h0, sniffActive, axisEnable}, 32'h7);
    for (k = 0; k < 8; k++) begin
      wr(A_PWR, pw[k]);
      wr(A_RATE, {4'h0, cd[k]});
      if (ex[k] > 0) measure(n);
      else quiet(n);
      check_count(n, ex[k]);
      apb(1'b0, A_STAT, 32'h0);
      check_flag(rv[0], ex[k] > 0);
    end
    $display("test rates done");

    // Software rate set up before its code is chosen
    wr(A_PWR, 8'h00);
    wr(A_RATE, 8'h40);
    wr(A_TUNE, 8'h00);
    wr(A_RATE, 8'h50);
    wr(A_TUNE, 8'h01);
    wr(A_RATE, 8'h0f);
    measure(n);
    check_count(n, 256);
    $display("test software rate done");

    wr(A_MODE, 8'h55);
    repeat (3) @(negedge clk);
    check_word({28'h0, sniffActive, axisEnable}, 32'h2);
    wr(A_MODE, 8'h06);
    repeat (3) @(negedge clk);
    check_word({28'h0, sniffActive, axisEnable}, 32'hf);
    wr(A_MODE, 8'h02);
    repeat (3) @(negedge clk);
    check_word({28'h0, sniffActive, axisEnable}, 32'h8);
    quiet(n);
    check_count(n, 0);
    $display("test modes done");
    give_verdict();
  end
endmodule
`default_nettype wire
